//--- design/pesc_pkg.sv
// Constants for the performance event select and count block.
// Assumes a single 20 MHz clock and an AXI4-Lite register master.
package pesc_pkg;

   // Register byte offsets.
   localparam logic [3:0] REG_EVSEL_OFS  = 4'h0;
   localparam logic [3:0] REG_COUNT_OFS  = 4'h4;
   localparam logic [3:0] REG_STATUS_OFS = 4'h8;

   // Event select field positions.
   localparam int EVSEL_CODE_LSB  = 0;
   localparam int EVSEL_UMASK_LSB = 8;
   localparam int EVSEL_EN_BIT    = 16;

   // Status field positions.
   localparam int STAT_THROTTLE_BIT = 0;
   localparam int STAT_HOT_BIT      = 1;
   localparam int STAT_HALTED_BIT   = 2;
   localparam int STAT_ACTIVE_BIT   = 3;

   // Reset values.
   localparam logic [7:0]  EVSEL_CODE_RST  = 8'h00;
   localparam logic [7:0]  EVSEL_UMASK_RST = 8'h00;
   localparam logic [31:0] COUNT_RST       = 32'h0000_0000;

   // Event codes and unit masks.
   localparam logic [7:0] EV_FREQ_TRANS   = 8'h3A;
   localparam logic [7:0] UM_FREQ_TRANS   = 8'h00;
   localparam logic [7:0] EV_THERMAL_TRIP = 8'h3B;
   localparam logic [7:0] UM_THERMAL_TRIP = 8'hC0;
   localparam logic [7:0] EV_UNHALTED     = 8'h3C;
   localparam logic [7:0] UM_CORE_CYCLE   = 8'h00;
   localparam logic [7:0] UM_BUS_CYCLE    = 8'h01;
   localparam logic [7:0] UM_SOLE_CORE    = 8'h02;
   localparam logic [7:0] EV_CACHE_READ   = 8'h40;
   localparam logic [7:0] EV_CACHE_WRITE  = 8'h41;
   localparam logic [7:0] EV_CACHE_LOCKRD = 8'h42;

   // Cache line state unit mask bits.
   localparam int UM_STATE_I_BIT = 0;
   localparam int UM_STATE_S_BIT = 1;
   localparam int UM_STATE_E_BIT = 2;
   localparam int UM_STATE_M_BIT = 3;

   // Cache line state codes on the access port.
   typedef enum logic [1:0] {LINE_I, LINE_S, LINE_E, LINE_M} pesc_line_type;

   // AXI responses.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Timing.
   localparam int CLK_KHZ        = 20000;
   localparam int CHECK_TIME_MS  = 1;
   localparam int CHECK_CYCLES   = CHECK_TIME_MS * CLK_KHZ;

endpackage

//--- design/pesc_top.sv
// Performance event selection and a single event counter with AXI4-Lite access.
// Event sources are synchronous pulses and levels from core, power and cache logic.
`timescale 1ns/1ps
module pesc_top
#(
   parameter int CNT_W        = 32,
   parameter int CHECK_CYCLES = pesc_pkg::CHECK_CYCLES
)
(
   // Clock, reset and enable.
   input  wire logic                  ref_clk,
   input  wire logic                  reset,
   input  wire logic                  clk_en,
   // AXI4-Lite write address and data.
   input  wire logic [3:0]            s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [3:0]            s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Core and power state.
   input  wire logic                  halt_instruction,
   input  wire logic                  other_core_halted,
   input  wire logic                  fully_active_power_state,
   input  wire logic                  freq_change_pulse,
   input  wire logic                  enhanced_sleep_state_entry,
   input  wire logic                  bus_cycle_tick,
   // Thermal sensor and throttle.
   input  wire logic                  temp_above_trip,
   output logic                       thermal_throttle,
   // Data cache access report.
   input  wire logic                  cache_access_valid,
   input  wire logic                  cache_access_write,
   input  wire logic                  cache_access_locked,
   input  wire logic                  cache_access_cacheable,
   input  wire pesc_pkg::pesc_line_type cache_access_line_state,
   // Counter value.
   output logic [CNT_W-1:0]           event_count
);
   import pesc_pkg::*;

   // Parameter values that the logic cannot serve stop elaboration.
   if (CNT_W < 1 || CNT_W > 32)
   begin : g_cnt_w_check
      $error("CNT_W must lie between 1 and 32.");
   end
   if (CHECK_CYCLES < 2)
   begin : g_check_cycles_check
      $error("CHECK_CYCLES must be at least 2.");
   end

   typedef struct packed {
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      logic             arready;
      logic             rvalid;
      logic [1:0]       rresp;
      logic [31:0]      rdata;
      logic             aw_got;
      logic [3:0]       aw_addr;
      logic             w_got;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic [7:0]       code;
      logic [7:0]       umask;
      logic             enable;
      logic [CNT_W-1:0] count;
      logic             throttle;
      logic             hot_q;
      logic [31:0]      check_cnt;
   } pesc_state_type;

   pesc_state_type r;
   pesc_state_type next_r;

   localparam logic [31:0] CHECK_LAST = 32'(CHECK_CYCLES - 1);

   // Applies byte strobes to a stored word.
   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = new_w[i*8 +: 8];
      end
      return res;
   endfunction

   // True when the line state of an access is enabled in the unit mask.
   function automatic logic state_selected(input logic [7:0]    um,
                                           input pesc_line_type st);
      logic sel;
      sel = 1'b0;
      unique case (st)
         LINE_I: sel = um[UM_STATE_I_BIT];
         LINE_S: sel = um[UM_STATE_S_BIT];
         LINE_E: sel = um[UM_STATE_E_BIT];
         LINE_M: sel = um[UM_STATE_M_BIT];
      endcase
      return sel;
   endfunction

   always_comb
   begin
      logic        aw_have;
      logic        w_have;
      logic [3:0]  wa;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic [31:0] evsel_word;
      logic [31:0] status_word;
      logic [31:0] count_word;
      logic [31:0] merged;
      logic        running;
      logic        trip;
      logic        transition;
      logic        cache_hit;
      logic        inc;
      aw_have     = 1'b0;
      w_have      = 1'b0;
      wa          = 4'h0;
      wd          = 32'h0000_0000;
      ws          = 4'h0;
      merged      = 32'h0000_0000;
      running     = 1'b0;
      trip        = 1'b0;
      transition  = 1'b0;
      cache_hit   = 1'b0;
      inc         = 1'b0;
      next_r      = r;

      evsel_word  = 32'h0000_0000;
      evsel_word[EVSEL_CODE_LSB +: 8]  = r.code;
      evsel_word[EVSEL_UMASK_LSB +: 8] = r.umask;
      evsel_word[EVSEL_EN_BIT]         = r.enable;
      status_word = 32'h0000_0000;
      status_word[STAT_THROTTLE_BIT] = r.throttle;
      status_word[STAT_HOT_BIT]      = temp_above_trip;
      status_word[STAT_HALTED_BIT]   = halt_instruction;
      status_word[STAT_ACTIVE_BIT]   = fully_active_power_state;
      count_word  = 32'(r.count);

      // Thermal trip detection and throttling.
      next_r.hot_q = temp_above_trip;
      trip = temp_above_trip & ~r.hot_q;
      if (trip)
      begin
         next_r.throttle  = 1'b1;
         next_r.check_cnt = 32'h0000_0000;
      end
      else if (r.throttle)
      begin
         if (r.check_cnt == CHECK_LAST)
         begin
            next_r.check_cnt = 32'h0000_0000;
            if (!temp_above_trip)
               next_r.throttle = 1'b0;
         end
         else
            next_r.check_cnt = r.check_cnt + 32'h0000_0001;
      end

      // A halted core stops every unhalted cycle event.
      running = ~halt_instruction;
      transition = fully_active_power_state &
                   (freq_change_pulse |
                    enhanced_sleep_state_entry | (next_r.throttle != r.throttle));
      cache_hit = cache_access_valid & cache_access_cacheable &
                  state_selected(r.umask, cache_access_line_state);

      // Both code and unit mask must match the occurrence.
      unique case (r.code)
         EV_FREQ_TRANS:
            inc = (r.umask == UM_FREQ_TRANS) & transition;
         EV_THERMAL_TRIP:
            inc = (r.umask == UM_THERMAL_TRIP) & trip;
         EV_UNHALTED:
         begin
            if (r.umask == UM_CORE_CYCLE)
               inc = running;
            else if (r.umask == UM_BUS_CYCLE)
               inc = running & bus_cycle_tick;
            else if (r.umask == UM_SOLE_CORE)
               inc = running & other_core_halted & bus_cycle_tick;
            else
               inc = 1'b0;
         end
         EV_CACHE_READ:
            inc = cache_hit & ~cache_access_write & ~cache_access_locked;
         EV_CACHE_WRITE:
            inc = cache_hit & cache_access_write & ~cache_access_locked;
         EV_CACHE_LOCKRD:
            inc = cache_hit & ~cache_access_write & cache_access_locked;
         default:
            inc = 1'b0;
      endcase
      if (r.enable && inc)
         next_r.count = r.count + CNT_W'(1);

      // Write channel: address and data may arrive in either order.
      aw_have = r.aw_got | (s_axi_awvalid & r.awready);
      w_have  = r.w_got | (s_axi_wvalid & r.wready);
      wa = r.aw_got ? r.aw_addr : s_axi_awaddr;
      wd = r.w_got ? r.wdata : s_axi_wdata;
      ws = r.w_got ? r.wstrb : s_axi_wstrb;
      if (s_axi_awvalid && r.awready)
      begin
         next_r.aw_got  = 1'b1;
         next_r.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r.wready)
      begin
         next_r.w_got = 1'b1;
         next_r.wdata = s_axi_wdata;
         next_r.wstrb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
         next_r.bvalid = 1'b0;
      if (aw_have && w_have && !r.bvalid)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got  = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp  = RESP_OKAY;
         if (wa == REG_EVSEL_OFS)
         begin
            merged       = merge_bytes(evsel_word, wd, ws);
            next_r.code   = merged[EVSEL_CODE_LSB +: 8];
            next_r.umask  = merged[EVSEL_UMASK_LSB +: 8];
            next_r.enable = merged[EVSEL_EN_BIT];
         end
         else if (wa == REG_COUNT_OFS)
         begin
            merged       = merge_bytes(count_word, wd, ws);
            next_r.count = merged[CNT_W-1:0];
         end
         else if (wa != REG_STATUS_OFS)
            next_r.bresp = RESP_SLVERR;
      end
      next_r.awready = ~next_r.aw_got & ~next_r.bvalid;
      next_r.wready  = ~next_r.w_got & ~next_r.bvalid;

      // Read channel.
      if (r.rvalid && s_axi_rready)
         next_r.rvalid = 1'b0;
      if (s_axi_arvalid && r.arready)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp  = RESP_OKAY;
         unique case (s_axi_araddr)
            REG_EVSEL_OFS:  next_r.rdata = evsel_word;
            REG_COUNT_OFS:  next_r.rdata = count_word;
            REG_STATUS_OFS: next_r.rdata = status_word;
            default:
            begin
               next_r.rdata = 32'h0000_0000;
               next_r.rresp = RESP_SLVERR;
            end
         endcase
      end
      next_r.arready = ~next_r.rvalid;
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         r           <= '0;
         r.awready   <= 1'b1;
         r.wready    <= 1'b1;
         r.arready   <= 1'b1;
         r.code      <= EVSEL_CODE_RST;
         r.umask     <= EVSEL_UMASK_RST;
         r.count     <= COUNT_RST[CNT_W-1:0];
      end
      else if (clk_en)
         r <= next_r;
   end

   assign s_axi_awready    = r.awready;
   assign s_axi_wready     = r.wready;
   assign s_axi_bvalid     = r.bvalid;
   assign s_axi_bresp      = r.bresp;
   assign s_axi_arready    = r.arready;
   assign s_axi_rvalid     = r.rvalid;
   assign s_axi_rresp      = r.rresp;
   assign s_axi_rdata      = r.rdata;
   assign thermal_throttle = r.throttle;
   assign event_count      = r.count;

endmodule

//--- tb/pesc_properties.sv
// Port checker for the event select and count block.
// Assumes the master offers write address and data in the same cycle.
`timescale 1ns/1ps
module pesc_properties
import pesc_pkg::*;
#(parameter int CNT_W = 32)
(
   // Clock and control.
   input wire logic             ref_clk,
   input wire logic             reset,
   input wire logic             clk_en,
   // Register bus.
   input wire logic [3:0]       s_axi_awaddr,
   input wire logic             s_axi_awvalid,
   input wire logic             s_axi_awready,
   input wire logic [31:0]      s_axi_wdata,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_bready,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic [31:0]      s_axi_rdata,
   input wire logic [1:0]       s_axi_rresp,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   // Event sources and results.
   input wire logic             halt_instruction,
   input wire logic             other_core_halted,
   input wire logic             bus_cycle_tick,
   input wire logic             temp_above_trip,
   input wire logic             thermal_throttle,
   input wire logic [CNT_W-1:0] event_count
);
   logic [16:0] sel;
   logic        wr;
   assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
   // Shadow of the select register, so each counting rule is checked only under its own event.
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         sel <= '0;
      else if (wr && s_axi_awaddr == REG_EVSEL_OFS)
         sel <= s_axi_wdata[16:0];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_READ_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata)) else $error("read data dropped");
   AST_CORE_CYCLE: assert property (sel == {1'b1, UM_CORE_CYCLE, EV_UNHALTED}
      && !halt_instruction && clk_en && !wr |=> event_count == CNT_W'($past(event_count) + 1))
      else $error("core cycle not counted");
   AST_HALT_STOPS: assert property (sel[7:0] == EV_UNHALTED && halt_instruction
      && clk_en && !wr |=> $stable(event_count)) else $error("counted while halted");
   AST_BUS_CYCLE: assert property (sel == {1'b1, UM_BUS_CYCLE, EV_UNHALTED}
      && !halt_instruction && bus_cycle_tick && clk_en && !wr
      |=> event_count == CNT_W'($past(event_count) + 1))
      else $error("bus cycle not counted");
   AST_SOLE_CORE: assert property (sel[15:0] == {UM_SOLE_CORE, EV_UNHALTED}
      && !other_core_halted && clk_en && !wr |=> $stable(event_count))
      else $error("sole core counted with other core running");
   AST_TRIP_COUNT: assert property (sel == {1'b1, UM_THERMAL_TRIP, EV_THERMAL_TRIP}
      && !temp_above_trip && clk_en && !wr ##1 temp_above_trip && clk_en && !wr
      |=> event_count == CNT_W'($past(event_count) + 1)) else $error("trip not counted");
   AST_TRIP_THROTTLE: assert property ($rose(temp_above_trip) && clk_en
      |=> thermal_throttle) else $error("no throttle after trip");
   AST_THROTTLE_HOLD: assert property (thermal_throttle && temp_above_trip && clk_en
      |=> thermal_throttle) else $error("throttle released while hot");
   AST_FREEZE: assert property (!clk_en |=> $stable(event_count) && $stable(thermal_throttle))
      else $error("state moved while frozen");
   cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_SLVERR);
   cover property (thermal_throttle ##1 !thermal_throttle);
   cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind pesc_top pesc_properties #(.CNT_W(CNT_W)) u_props (.*);

//--- tb/pesc_bus_src.sv
// Bus clock source beside the core: one tick every RATIO core cycles.
// Assumes a synchronous active-high reset on the core clock.
`timescale 1ns/1ps
module pesc_bus_src
#(parameter int RATIO = 4)
(
   // Clock and reset.
   input  wire logic ref_clk,
   input  wire logic reset,
   // Bus clock tick.
   output logic      bus_cycle_tick
);
   int phase;
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         phase <= 0;
      else
         phase <= (phase == RATIO - 1) ? 0 : phase + 1;
   end
   // A fixed period keeps bus ticks in constant ratio to reference cycles.
   assign bus_cycle_tick = (phase == RATIO - 1);
endmodule

//--- tb/pesc_top_tb_top.sv
// Self-checking bench for the event select and count block.
// Assumes a 20 MHz ref_clk and the bus source model beside the block.
`timescale 1ns/1ps
module pesc_top_tb_top;
   import pesc_pkg::*;
   localparam int RATIO = 4;
   logic ref_clk = 0, reset = 1, clk_en = 1;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata;
   logic awready, wready, bvalid, arready, rvalid, tick, throttle;
   logic [1:0] bresp, rresp, r;
   logic halt = 0, other = 0, active = 1, freq = 0, sleep = 0, temp = 0;
   logic cv = 0, cw = 0, cl = 0, cc = 1;
   pesc_line_type cs = LINE_I;
   logic [31:0] count, snap, d;
   int errors = 0, n_compared = 0, exp_n;
   pesc_bus_src #(.RATIO(RATIO)) u_bus (.ref_clk(ref_clk), .reset(reset),
      .bus_cycle_tick(tick));
   pesc_top #(.CNT_W(32), .CHECK_CYCLES(8)) dut (.ref_clk(ref_clk), .reset(reset),
      .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .halt_instruction(halt), .other_core_halted(other), .fully_active_power_state(active),
      .freq_change_pulse(freq), .enhanced_sleep_state_entry(sleep), .bus_cycle_tick(tick),
      .temp_above_trip(temp), .thermal_throttle(throttle), .cache_access_valid(cv),
      .cache_access_write(cw), .cache_access_locked(cl), .cache_access_cacheable(cc),
      .cache_access_line_state(cs), .event_count(count));
   always #25 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      for (int k = 0; k < 20; k++)
      begin
         @(posedge ref_clk);
         if (awvalid && awready)
            awvalid <= 0;
         if (wvalid && wready)
            wvalid <= 0;
         if (bvalid)
         begin
            r = bresp;
            bready <= 0;
            return;
         end
      end
      errors++;
      print_verdict();
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      for (int k = 0; k < 20; k++)
      begin
         @(posedge ref_clk);
         if (arvalid && arready)
            arvalid <= 0;
         if (rvalid)
         begin
            d = rdata;
            r = rresp;
            rready <= 0;
            return;
         end
      end
      errors++;
      print_verdict();
   endtask
   task automatic sel(input logic [7:0] code, input logic [7:0] um);
      wr(REG_EVSEL_OFS, {15'h0, 1'b1, um, code}, 4'hF);
   endtask
   task automatic measure(input int n, input logic [31:0] exp);
      @(posedge ref_clk);
      #1 snap = count;
      repeat (n) @(posedge ref_clk);
      #1 check("count delta", count - snap, exp);
   endtask
   task automatic t_regs();
      rd(REG_EVSEL_OFS);
      check("evsel reset", d, 32'h0);
      rd(REG_STATUS_OFS);
      check("status", d, 32'h8);
      check("read resp", r, RESP_OKAY);
      rd(4'hC);
      check("unmapped read", {d[29:0], r}, {30'h0, RESP_SLVERR});
      wr(4'hC, 32'h0, 4'hF);
      check("unmapped write", r, RESP_SLVERR);
      sel(EV_CACHE_LOCKRD, 8'hFF);
      check("write resp", r, RESP_OKAY);
      rd(REG_EVSEL_OFS);
      check("evsel", d, 32'h0001_FF42);
      wr(REG_COUNT_OFS, 32'h1234_5678, 4'hF);
      wr(REG_COUNT_OFS, 32'h0000_00AB, 4'h1);
      rd(REG_COUNT_OFS);
      check("count merge", d, 32'h1234_56AB);
   endtask
   task automatic t_core();
      sel(EV_UNHALTED, UM_CORE_CYCLE);
      measure(10, 10);
      @(posedge ref_clk);
      halt <= 1;
      measure(6, 0);
      rd(REG_STATUS_OFS);
      check("status halted", d, 32'hC);
      @(posedge ref_clk);
      halt <= 0;
      clk_en <= 0;
      measure(5, 0);
      @(posedge ref_clk);
      clk_en <= 1;
      sel(EV_UNHALTED, 8'h05);
      measure(8, 0);
   endtask
   task automatic t_freq();
      sel(EV_FREQ_TRANS, UM_FREQ_TRANS);
      #1 snap = count;
      exp_n = 0;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge ref_clk);
         freq <= i[0];
         sleep <= i[1];
         active <= i[2];
         exp_n += i[2] && (i[0] || i[1]);
      end
      @(posedge ref_clk);
      freq <= 0;
      sleep <= 0;
      @(posedge ref_clk);
      #1 check("transitions", count - snap, exp_n);
   endtask
   task automatic t_bus();
      for (int j = 0; j < 2; j++)
      begin
         sel(EV_UNHALTED, (j == 1) ? UM_SOLE_CORE : UM_BUS_CYCLE);
         for (int i = 0; i < 4; i++)
         begin
            @(posedge ref_clk);
            halt <= i[0];
            other <= i[1];
            measure(2 * RATIO, (!i[0] && (j == 0 || i[1])) ? 2 : 0);
         end
      end
      @(posedge ref_clk);
      halt <= 0;
      other <= 0;
   endtask
   task automatic t_cache();
      logic [7:0] um;
      for (int j = 0; j < 3; j++)
      begin
         um = (j == 0) ? 8'h0A : (j == 1) ? 8'h05 : 8'h0C;
         sel(8'(EV_CACHE_READ + j), um);
         #1 snap = count;
         exp_n = 0;
         for (int i = 0; i < 32; i++)
         begin
            @(posedge ref_clk);
            cv <= 1;
            cw <= i[0];
            cl <= i[1];
            cs <= pesc_line_type'(i[3:2]);
            cc <= i[4] | i[3];
            exp_n += (i[4] || i[3]) && um[i[3:2]] && (i[1:0] == 2'(j));
         end
         @(posedge ref_clk);
         cv <= 0;
         @(posedge ref_clk);
         #1 check("cache events", count - snap, exp_n);
      end
   endtask
   task automatic t_thermal(input logic [7:0] code, input logic [7:0] um, input int per);
      sel(code, um);
      #1 snap = count;
      @(posedge ref_clk);
      temp <= 1;
      @(posedge ref_clk);
      #1 check("throttle on", throttle, 1'b1);
      rd(REG_STATUS_OFS);
      check("status hot", d, 32'hB);
      repeat (17) @(posedge ref_clk);
      temp <= 0;
      @(posedge ref_clk);
      #1 check("throttle held", throttle, 1'b1);
      for (int k = 0; k < 10 && throttle === 1'b1; k++)
         @(posedge ref_clk);
      @(posedge ref_clk);
      #1 check("throttle off", throttle, 1'b0);
      check("trip count", count - snap, per);
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset <= 0;
      t_regs();
      t_core();
      t_freq();
      t_bus();
      t_cache();
      t_thermal(EV_THERMAL_TRIP, UM_THERMAL_TRIP, 1);
      t_thermal(EV_FREQ_TRANS, UM_FREQ_TRANS, 2);
      print_verdict();
   end
endmodule
